/* File: core/tlf_consts.svh */
`ifndef TLF_CONSTS_SVH
`define TLF_CONSTS_SVH

// Accept-timing header characters sent first in the timing string
`define TLF_ACC_CHAR0       8'h41
`define TLF_ACC_CHAR1       8'h54
// Byte positions within the timing string, counted from 1
`define TLF_POS_FIRST       16'h0001
`define TLF_POS_CNT_MSB     16'h0003
`define TLF_POS_CNT_LSB     16'h0004
`define TLF_POS_CRC_START   16'h0005
`define TLF_POS_CHANNELS    16'h0005
`define TLF_POS_VALID       16'h0006
`define TLF_POS_TRACEPT     16'h0008
`define TLF_POS_GLITCH      16'h000a
`define TLF_POS_PERIOD      16'h000b
`define TLF_POS_DATETIME    16'h000d
`define TLF_POS_DELAY       16'h0014
`define TLF_POS_UNIT        16'h0016
`define TLF_POS_DURATION    16'h0017
`define TLF_POS_MASTER      16'h001b
`define TLF_POS_HDR_LAST    16'h001b
`define TLF_POS_REC_START   16'h001c
// Bytes after the count field other than records: 23 header + 2 CRC
`define TLF_CNT_FIXED       17'h00019
`define TLF_CNT_MAX         16'h28fb
`define TLF_CNT_CRC_BYTES   16'h0002
`define TLF_TE_MAX_BYTES    16'h1564
// Delay unit codes
`define TLF_UNIT_NS         2'h0
`define TLF_UNIT_US         2'h1
`define TLF_UNIT_MS         2'h2
`define TLF_UNIT_S          2'h3
// Line end for non-binary transfers
`define TLF_CHAR_CR         8'h0d
`define TLF_CHAR_LF         8'h0a
// Channel count per record byte
`define TLF_CHANNELS        8'h08
// CRC defaults
`define TLF_CRC_POLY        16'h1021
`define TLF_CRC_SEED        16'h0000

`endif

/* File: core/tlf_crc_step.sv */
`timescale 1ns/100ps
// One byte step of an MSB-first CRC, shared by transmit and receive
module tlf_crc_step #(
  parameter logic [15:0] POLY = 16'h1021
) (
  input  wire logic [15:0] crc_in,   // Running CRC
  input  wire logic [7:0]  data_in,  // Byte to fold in
  output      logic [15:0] crc_out   // Updated CRC
);

  logic [15:0] chain [0:8];

  assign chain[0] = crc_in;

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      wire fb = chain[b][15] ^ data_in[7 - b];
      assign chain[b + 1] = {chain[b][14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
    end
  endgenerate

  assign crc_out = chain[8];

endmodule

/* File: core/tlf_framer.sv */
`timescale 1ns/100ps
`include "tlf_consts.svh"
//
// Function
// [R1] Timing transmit command sends timing data ending with two CRC bytes.
// [R2] Glitch mode adds a glitch byte after each record byte.
// [R3] Each record is one byte, channel bits 7..0 of pod 0.
// [R4] String starts with the two accept-timing header characters.
// [R5] Bytes 3-4 carry the byte count; CRC starts at byte 5.
// [R6] Channels, valid count, tracepoint, glitch flag, period, date/time follow.
// [R7] Bytes 20-21 post-trigger delay, byte 22 its unit code 0..3.
// [R8] Four-byte pattern duration at 23, state-master flag at 27.
// [R9] Records from byte 28; CRC stops after them; CRC at N+28.
// [R10] Count equals bytes following it including CRC; at most 10491. Code clamps the count at 10491 but still sends every record.
// [R11] Partial memory: count covers records to last stored word plus CRC.
// [R12] Real fields carry counts of marks or sample intervals.
// [R13] Send-all sends config, then state, then timing string.
// [R14] Send-all total is the sum of the component strings.
// [R15] Binary transfer ends with EOI on the final byte.
// [R16] Non-binary transfer ends with CR LF, EOI on LF.
// [R17] Received learn string with wrong CRC is rejected with an error.
// [R18] Byte count goes most significant byte first.
// [R19] CRC generator is parameterised and shared by transmit and receive.
//
module tlf_framer #(
  parameter logic [15:0] CRC_POLY = `TLF_CRC_POLY,
  parameter logic [15:0] CRC_SEED = `TLF_CRC_SEED
) (
  input  wire logic                    clk,                 // Clock, 50 MHz
  input  wire logic                    rst,                 // Synchronous reset
  input  wire logic                    ce,                  // Clock enable
  input  wire logic                    send_timing_acq_cmd, // Timing string command pulse
  input  wire logic                    send_all_strings_cmd,// Send-all command pulse
  input  wire logic                    send_config_cmd,     // Config string command pulse
  input  wire logic                    send_state_acq_cmd,  // State string command pulse
  input  wire logic                    send_text_cmd,       // Non-binary reply command pulse
  input  wire tlf_pkg::tlf_timing_hdr_s timing_hdr,         // Timing header fields
  output      logic                    src_start,           // Start pulse to byte source
  output      tlf_pkg::tlf_src_e       src_sel,             // Selected byte source
  input  wire logic                    src_valid,           // Source byte valid
  input  wire logic [7:0]              src_byte,            // Source byte
  input  wire logic                    src_last,            // Last byte of source string
  output      logic                    src_ready,           // Source byte taken
  output      logic [15:0]             rec_addr,            // Record memory address
  input  wire logic [7:0]              rec_data,            // Record byte, pod 0 bits 7..0
  input  wire logic [7:0]              rec_glitch,          // Glitch byte of record
  output      tlf_pkg::tlf_bus_byte_s  out_bus,             // Outgoing byte and EOI
  output      logic                    out_valid,           // Outgoing byte valid
  input  wire logic                    out_ready,           // Bus took the byte
  output      logic                    busy,                // Transfer in progress
  input  wire logic                    rx_valid,            // Received byte strobe
  input  wire logic [7:0]              rx_byte,             // Received byte
  input  wire logic                    rx_eoi,              // Received EOI
  output      logic                    rx_ok,               // Received string accepted
  output      logic                    rx_crc_err           // Received CRC mismatch
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FWD,
    ST_HDR,
    ST_REC_A,
    ST_REC_W,
    ST_REC_D,
    ST_CRC,
    ST_CRLF
  } tlf_state_e;

  tlf_state_e              state;
  tlf_pkg::tlf_timing_hdr_s hdr;
  logic [15:0]             pos;
  logic [15:0]             crc;
  logic                    all_mode;
  logic                    rec_half;
  logic                    tail;

  ////////////////////////////////////////////////////////////////////////////
  // Length and header bytes

  wire [16:0] rec_bytes  = hdr.glitch_on ? {hdr.valid_states, 1'b0}      // [R2]
                                         : {1'b0, hdr.valid_states};     // [R11]
  wire [16:0] cnt_full   = rec_bytes + `TLF_CNT_FIXED;                   // [R10]
  wire [15:0] byte_count = (cnt_full > {1'b0, `TLF_CNT_MAX}) ? `TLF_CNT_MAX
                                                             : cnt_full[15:0];
  wire        no_records = hdr.valid_states == 16'h0000;
  wire        last_rec   = rec_addr == hdr.valid_states - 16'h0001;

  wire [215:0] hdr_flat = {`TLF_ACC_CHAR0, `TLF_ACC_CHAR1,                 // [R4]
                           byte_count,                                     // [R5] [R18]
                           hdr.channels, hdr.valid_states, hdr.tracepoint, // [R6]
                           7'h00, hdr.glitch_on, hdr.sample_period, hdr.date_time,
                           hdr.delay_count, 6'h00, hdr.delay_unit,         // [R7]
                           hdr.pattern_dur, 7'h00, hdr.state_master};      // [R8] [R12]
  logic [7:0] hdr_tab [1:27];

  genvar k;
  generate
    for (k = 1; k < 28; k++) begin : g_hdr
      assign hdr_tab[k] = hdr_flat[223 - 8 * k -: 8];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Byte selection and CRC

  wire        can_emit  = !out_valid || out_ready;
  wire [4:0]  hdr_idx   = pos[4:0];
  wire [7:0]  hdr_byte  = hdr_tab[hdr_idx];
  wire [7:0]  rec_byte  = rec_half ? rec_glitch : rec_data;              // [R3]
  wire [7:0]  crc_byte  = (state == ST_REC_D) ? rec_byte : hdr_byte;
  wire        hdr_crc   = pos >= `TLF_POS_CRC_START;                     // [R5]
  wire        src_take  = src_valid && src_ready;
  wire        text_src  = src_sel == tlf_pkg::TLF_SRC_TEXT;
  logic [15:0] crc_next;

  assign src_ready = (state == ST_FWD) && can_emit && ce;
  assign busy      = state != ST_IDLE;

  tlf_crc_step #(.POLY(CRC_POLY)) u_tx_crc (
    .crc_in  (crc),
    .data_in (crc_byte),
    .crc_out (crc_next)                                                  // [R19]
  );

  tlf_rx_check #(.POLY(CRC_POLY), .SEED(CRC_SEED)) u_rx (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .rx_valid   (rx_valid),
    .rx_byte    (rx_byte),
    .rx_eoi     (rx_eoi),
    .rx_ok      (rx_ok),
    .rx_crc_err (rx_crc_err)                                             // [R17]
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      hdr       <= '0;
      pos       <= `TLF_POS_FIRST;
      crc       <= CRC_SEED;
      all_mode  <= 1'b0;
      rec_half  <= 1'b0;
      tail      <= 1'b0;
      rec_addr  <= 16'h0000;
      src_start <= 1'b0;
      src_sel   <= tlf_pkg::TLF_SRC_CONFIG;
      out_bus   <= '0;
      out_valid <= 1'b0;
    end else if (ce) begin
      src_start <= 1'b0;
      if (out_valid && out_ready) out_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          all_mode <= send_all_strings_cmd;
          if (send_all_strings_cmd || send_config_cmd) begin            // [R13]
            src_sel   <= tlf_pkg::TLF_SRC_CONFIG;
            src_start <= 1'b1;
            state     <= ST_FWD;
          end else if (send_state_acq_cmd) begin
            src_sel   <= tlf_pkg::TLF_SRC_STATE;
            src_start <= 1'b1;
            state     <= ST_FWD;
          end else if (send_timing_acq_cmd) begin                       // [R1]
            hdr   <= timing_hdr;
            pos   <= `TLF_POS_FIRST;
            crc   <= CRC_SEED;
            state <= ST_HDR;
          end else if (send_text_cmd) begin
            src_sel   <= tlf_pkg::TLF_SRC_TEXT;
            src_start <= 1'b1;
            state     <= ST_FWD;
          end
        end
        ST_FWD: begin
          if (src_take) begin
            out_bus   <= '{data: src_byte, eoi: src_last && !all_mode && !text_src}; // [R15]
            out_valid <= 1'b1;
            if (src_last) begin
              if (text_src) begin
                tail  <= 1'b0;
                state <= ST_CRLF;
              end else if (all_mode && src_sel == tlf_pkg::TLF_SRC_CONFIG) begin
                src_sel   <= tlf_pkg::TLF_SRC_STATE;                    // [R13] [R14]
                src_start <= 1'b1;
              end else if (all_mode) begin
                hdr   <= timing_hdr;
                pos   <= `TLF_POS_FIRST;
                crc   <= CRC_SEED;
                state <= ST_HDR;                                        // [R13]
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_HDR: begin
          if (can_emit) begin
            out_bus   <= '{data: hdr_byte, eoi: 1'b0};
            out_valid <= 1'b1;
            if (hdr_crc) crc <= crc_next;                               // [R5]
            pos <= pos + 16'h0001;
            if (pos == `TLF_POS_HDR_LAST) begin
              rec_addr <= 16'h0000;
              rec_half <= 1'b0;
              tail     <= 1'b0;
              state    <= no_records ? ST_CRC : ST_REC_A;               // [R9]
            end
          end
        end
        ST_REC_A: state <= ST_REC_W;
        ST_REC_W: state <= ST_REC_D;
        ST_REC_D: begin
          if (can_emit) begin
            out_bus   <= '{data: rec_byte, eoi: 1'b0};                  // [R3]
            out_valid <= 1'b1;
            crc       <= crc_next;                                      // [R9]
            if (hdr.glitch_on && !rec_half) begin
              rec_half <= 1'b1;                                         // [R2]
            end else begin
              rec_half <= 1'b0;
              if (last_rec) begin
                state <= ST_CRC;                                        // [R9]
              end else begin
                rec_addr <= rec_addr + 16'h0001;
                state    <= ST_REC_A;
              end
            end
          end
        end
        ST_CRC: begin
          if (can_emit) begin
            out_bus   <= '{data: tail ? crc[7:0] : crc[15:8], eoi: tail}; // [R1] [R15]
            out_valid <= 1'b1;
            tail      <= !tail;
            if (tail) state <= ST_IDLE;
          end
        end
        ST_CRLF: begin
          if (can_emit) begin
            out_bus   <= '{data: tail ? `TLF_CHAR_LF : `TLF_CHAR_CR, eoi: tail}; // [R16]
            out_valid <= 1'b1;
            tail      <= !tail;
            if (tail) state <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule

/* File: core/tlf_pkg.sv */
package tlf_pkg;

  typedef enum logic [1:0] {
    TLF_SRC_CONFIG,
    TLF_SRC_STATE,
    TLF_SRC_TEXT
  } tlf_src_e;

  typedef struct packed {
    logic [7:0]  channels;
    logic [15:0] valid_states;
    logic [15:0] tracepoint;
    logic        glitch_on;
    logic [15:0] sample_period;
    logic [55:0] date_time;
    logic [15:0] delay_count;
    logic [1:0]  delay_unit;
    logic [31:0] pattern_dur;
    logic        state_master;
  } tlf_timing_hdr_s;

  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } tlf_bus_byte_s;

endpackage

/* File: core/tlf_rx_check.sv */
`timescale 1ns/100ps
`include "tlf_consts.svh"
// Checks the CRC of a received learn string
module tlf_rx_check #(
  parameter logic [15:0] POLY = `TLF_CRC_POLY,
  parameter logic [15:0] SEED = `TLF_CRC_SEED
) (
  input  wire logic       clk,       // Clock
  input  wire logic       rst,       // Synchronous reset
  input  wire logic       ce,        // Clock enable
  input  wire logic       rx_valid,  // Received byte strobe
  input  wire logic [7:0] rx_byte,   // Received byte
  input  wire logic       rx_eoi,    // End marker with byte
  output      logic       rx_ok,     // String accepted pulse
  output      logic       rx_crc_err // CRC mismatch pulse, string rejected
);

  logic [15:0] pos;
  logic [15:0] count;
  logic [15:0] crc;
  logic [7:0]  crc_hi;
  logic [15:0] crc_step;

  wire [15:0] last_pos  = count + `TLF_CNT_CRC_BYTES + `TLF_CNT_CRC_BYTES;
  wire [15:0] data_last = count + `TLF_CNT_CRC_BYTES;
  wire        in_data   = (pos >= `TLF_POS_CRC_START) && (pos <= data_last);
  wire        is_hi     = pos == data_last + 16'h0001;
  wire        is_lo     = (pos > `TLF_POS_CNT_LSB) && (pos == last_pos);
  wire        match     = {crc_hi, rx_byte} == crc;

  tlf_crc_step #(.POLY(POLY)) u_crc (
    .crc_in  (crc),
    .data_in (rx_byte),
    .crc_out (crc_step)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      pos        <= 16'h0001;
      count      <= 16'h0000;
      crc        <= SEED;
      crc_hi     <= 8'h00;
      rx_ok      <= 1'b0;
      rx_crc_err <= 1'b0;
    end else if (ce) begin
      rx_ok      <= 1'b0;
      rx_crc_err <= 1'b0;
      if (rx_valid) begin
        pos <= pos + 16'h0001;
        if (pos == `TLF_POS_CNT_MSB) count[15:8] <= rx_byte;
        if (pos == `TLF_POS_CNT_LSB) count[7:0] <= rx_byte;
        if (in_data) crc <= crc_step; // [R19]
        if (is_hi) crc_hi <= rx_byte;
        if (is_lo || rx_eoi) begin
          pos        <= 16'h0001;
          crc        <= SEED;
          rx_ok      <= is_lo && match;
          rx_crc_err <= !(is_lo && match); // [R17]
        end
      end
    end
  end

endmodule

/* File: verif/tlf_bus_host.sv */
`timescale 1ns/100ps
module tlf_bus_host (
  input  wire logic                   clk,       // Clock
  input  wire logic                   rst,       // Reset
  input  wire logic                   slow,      // Stall three cycles of four
  input  wire tlf_pkg::tlf_bus_byte_s out_bus,   // Byte and EOI
  input  wire logic                   out_valid, // Byte offered
  output      logic                   out_ready  // Byte taken
);
  logic [1:0] phase = 2'h0;
  logic [8:0] got [$];
  initial out_ready = 1'b0;
  ////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    phase <= phase + 2'h1;
    out_ready <= !rst && (!slow || phase == 2'h3);
  end
  always @(posedge clk) begin
    if (!rst && out_valid && out_ready) got.push_back({out_bus.data, out_bus.eoi});
  end
endmodule

/* File: verif/tlf_framer_props.sv */
`timescale 1ns/100ps
module tlf_framer_props (
  input wire logic                     clk,                  // Clock
  input wire logic                     rst,                  // Reset
  input wire logic                     ce,                   // Enable
  input wire logic                     send_timing_acq_cmd,  // Timing command
  input wire logic                     send_all_strings_cmd, // Send-all command
  input wire logic                     send_config_cmd,      // Config command
  input wire logic                     send_state_acq_cmd,   // State command
  input wire logic                     send_text_cmd,        // Text command
  input wire tlf_pkg::tlf_timing_hdr_s timing_hdr,           // Header fields
  input wire logic                     src_start,            // Source start
  input wire tlf_pkg::tlf_src_e        src_sel,              // Source select
  input wire logic                     src_valid,            // Source valid
  input wire logic                     src_last,             // Source last
  input wire logic                     src_ready,            // Source taken
  input wire tlf_pkg::tlf_bus_byte_s   out_bus,              // Byte and EOI
  input wire logic                     out_valid,            // Byte offered
  input wire logic                     out_ready,            // Byte taken
  input wire logic                     busy                  // Busy
);
  logic        tmode;
  logic        amode;
  logic [15:0] pos;
  logic [16:0] cnt;
  wire any_cmd = send_timing_acq_cmd || send_all_strings_cmd || send_config_cmd
                 || send_state_acq_cmd || send_text_cmd;
  wire t_take  = ce && !busy && send_timing_acq_cmd && !send_all_strings_cmd
                 && !send_config_cmd && !send_state_acq_cmd;
  wire a_take  = ce && !busy && send_all_strings_cmd;
  wire o_take  = ce && out_valid && out_ready;
  wire s_last  = ce && src_valid && src_ready && src_last;
  wire t_out   = tmode && out_valid;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Offered byte position in a timing string
  always_ff @(posedge clk) begin
    if (rst || (o_take && out_bus.eoi)) begin
      tmode <= 1'b0;
      amode <= 1'b0;
    end else begin
      tmode <= tmode || t_take;
      amode <= amode || a_take;
    end
    pos <= t_take ? 16'h0001 : pos + {15'h0000, tmode && o_take};
    cnt <= t_take ? 17'h00019 + ({1'b0, timing_hdr.valid_states} << timing_hdr.glitch_on) : cnt;
  end
  ////////////////////////////////////////////////////////////
  property p_first; t_take |-> ##2 out_valid && out_bus.data == 8'h41 && !out_bus.eoi; endproperty
  a_first: assert property (p_first) else $error("first header byte wrong");
  property p_second; t_out && pos == 16'h0002 |-> out_bus.data == 8'h54; endproperty
  a_second: assert property (p_second) else $error("second header byte wrong");
  property p_cnt_hi; t_out && pos == 16'h0003 |-> out_bus.data == cnt[15:8]; endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count high byte wrong");
  property p_cnt_lo; t_out && pos == 16'h0004 |-> out_bus.data == cnt[7:0]; endproperty
  a_cnt_lo: assert property (p_cnt_lo) else $error("count low byte wrong");
  property p_unit;
    t_out && pos == 16'h0016 |-> out_bus.data == {6'h00, timing_hdr.delay_unit};
  endproperty
  a_unit: assert property (p_unit) else $error("delay unit byte wrong");
  property p_master; t_out && pos == 16'h001b |-> out_bus.data[7:1] == 7'h00; endproperty
  a_master: assert property (p_master) else $error("master flag byte wrong");
  property p_end; t_out && out_bus.eoi |-> {1'b0, pos} == cnt + 17'h00004; endproperty
  a_end: assert property (p_end) else $error("string length wrong");
  property p_done; o_take && out_bus.eoi && !any_cmd |=> !out_valid && !busy; endproperty
  a_done: assert property (p_done) else $error("bytes after final byte");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_bus); endproperty
  a_hold: assert property (p_hold) else $error("offered byte changed");
  property p_all_start; a_take |=> src_start && src_sel == tlf_pkg::TLF_SRC_CONFIG; endproperty
  a_all_start: assert property (p_all_start) else $error("send-all not config first");
  property p_all_state;
    amode && s_last && src_sel == tlf_pkg::TLF_SRC_CONFIG |-> ##[1:8] src_start
      && src_sel == tlf_pkg::TLF_SRC_STATE;
  endproperty
  a_all_state: assert property (p_all_state) else $error("state not after config");
  property p_text; out_valid && out_bus.eoi && !tmode && src_sel == tlf_pkg::TLF_SRC_TEXT
    |-> out_bus.data == 8'h0a; endproperty
  a_text: assert property (p_text) else $error("text end not line feed");
endmodule

bind tlf_framer tlf_framer_props i_props (.clk, .rst, .ce, .send_timing_acq_cmd,
  .send_all_strings_cmd, .send_config_cmd, .send_state_acq_cmd, .send_text_cmd, .timing_hdr,
  .src_start, .src_sel, .src_valid, .src_last, .src_ready, .out_bus, .out_valid, .out_ready, .busy);

/* File: verif/tlf_framer_tb.sv */
`timescale 1ns/100ps
module tlf_framer_tb;
  logic                     clk       = 1'b0;
  logic                     rst       = 1'b1;
  logic [4:0]               cmd       = 5'h00;
  tlf_pkg::tlf_timing_hdr_s hdr       = '0;
  logic                     src_valid = 1'b0;
  logic [7:0]               src_byte  = 8'h00;
  logic                     src_last  = 1'b0;
  logic                     rx_valid  = 1'b0;
  logic [7:0]               rx_byte   = 8'h00;
  logic                     rx_eoi    = 1'b0;
  logic                     slow      = 1'b0;
  logic [7:0]               salt      = 8'h00;
  logic [15:0]              crc;
  logic [2:0]               src_len [3];
  logic [8:0]               exp_q [$];
  logic [191:0]             rnd;
  tlf_pkg::tlf_bus_byte_s   out_bus;
  tlf_pkg::tlf_src_e        src_sel;
  logic                     src_start, src_ready, out_valid, out_ready, busy, rx_ok, rx_crc_err;
  logic [15:0]              rec_addr;
  logic [7:0]               rec_data, rec_glitch;
  int                       err_total = 0;
  int                       compares  = 0;
  int                       cyc       = 0;
  ////////////////////////////////////////////////////////////
  tlf_framer i_dut (.clk, .rst, .ce(1'b1), .send_timing_acq_cmd(cmd[0]),
    .send_all_strings_cmd(cmd[1]), .send_config_cmd(cmd[2]), .send_state_acq_cmd(cmd[3]),
    .send_text_cmd(cmd[4]), .timing_hdr(hdr), .src_start, .src_sel, .src_valid, .src_byte,
    .src_last, .src_ready, .rec_addr, .rec_data, .rec_glitch, .out_bus, .out_valid, .out_ready,
    .busy, .rx_valid, .rx_byte, .rx_eoi, .rx_ok, .rx_crc_err);
  tlf_bus_host i_host (.clk, .rst, .slow, .out_bus, .out_valid, .out_ready);
  assign rec_data   = rec_val(rec_addr, 1'b0);
  assign rec_glitch = rec_val(rec_addr, 1'b1);
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] rec_val(input logic [15:0] a, input logic g);
    return a[7:0] ^ a[15:8] ^ {g, 7'h35};
  endfunction
  function automatic logic [7:0] sb(input logic [1:0] s, input int i);
    return salt ^ {s, i[5:0]};
  endfunction
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  task automatic push(input logic [7:0] b, input logic e);
    exp_q.push_back({b, e});
  endtask
  task automatic pc(input logic [7:0] b);
    push(b, 1'b0);
    crc = crc_step(crc, b);
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic new_hdr(input int t);
    exp_q.delete();
    rnd = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
    hdr = rnd[163:0];
    hdr.channels = 8'h08;
    hdr.valid_states = (t == 0) ? 16'h0000 : 16'($urandom_range(6, 1));
    hdr.glitch_on = t[0];
    salt = rnd[191:184];
    slow = t[1];
    foreach (src_len[i]) src_len[i] = 3'($urandom_range(6, 1));
  endtask
  task automatic add_src(input int s, input logic e);
    for (int i = 0; i < src_len[s]; i++) push(sb(s[1:0], i), e && i == src_len[s] - 1);
  endtask
  task automatic add_timing(input logic fin);
    logic [183:0] hb;
    logic [15:0]  n;
    hb = {hdr.channels, hdr.valid_states, hdr.tracepoint, 7'h00, hdr.glitch_on, hdr.sample_period,
          hdr.date_time, hdr.delay_count, 6'h00, hdr.delay_unit, hdr.pattern_dur, 7'h00,
          hdr.state_master};
    n = 16'h0019 + (hdr.valid_states << hdr.glitch_on);
    crc = 16'h0000;
    push(8'h41, 1'b0);
    push(8'h54, 1'b0);
    push(n[15:8], 1'b0);
    push(n[7:0], 1'b0);
    for (int i = 0; i < 23; i++) pc(hb[183 - 8 * i -: 8]);
    for (int r = 0; r < hdr.valid_states; r++) begin
      pc(rec_val(16'(r), 1'b0));
      if (hdr.glitch_on) pc(rec_val(16'(r), 1'b1));
    end
    push(crc[15:8], 1'b0);
    push(crc[7:0], fin);
  endtask
  // Pulse a command, poke config while a timing string is busy, compare bytes
  task automatic run(input logic [4:0] c, input string name);
    int n;
    n = 0;
    i_host.got.delete();
    cmd = c;
    @(negedge clk);
    cmd = (c == 5'h01) ? 5'h04 : 5'h00;
    @(negedge clk);
    cmd = 5'h00;
    while ((busy !== 1'b0 || out_valid !== 1'b0) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) err_total++;
    chk("length", 16'(i_host.got.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) chk("byte", (i < i_host.got.size()) ? i_host.got[i] : 9'bx, exp_q[i]);
    $display("test %s done", name);
  endtask
  task automatic rx_send(input logic bad);
    logic ok, er;
    {ok, er} = 2'b00;
    foreach (exp_q[i]) begin
      rx_valid = 1'b1;
      rx_byte  = exp_q[i][8:1] ^ {7'h00, bad && i == 12};
      rx_eoi   = exp_q[i][0];
      @(negedge clk);
    end
    rx_valid = 1'b0;
    rx_eoi   = 1'b0;
    rx_byte  = ~rx_byte;
    repeat (3) begin
      ok = ok | (rx_ok === 1'b1);
      er = er | (rx_crc_err === 1'b1);
      @(negedge clk);
    end
    chk("rx_ok", {15'h0000, ok}, {15'h0000, !bad});
    chk("rx_crc_err", {15'h0000, er}, {15'h0000, bad});
    $display("test receive done");
  endtask
  ////////////////////////////////////////////////////////////
  // Byte source answering each start of a forwarded string
  initial forever begin
    if (src_start !== 1'b1) begin
      src_valid = 1'b0;
      src_last  = 1'b0;
      src_byte  = ~src_byte;
      @(negedge clk);
    end else for (int i = 0; i == 0 || !src_last; i++) begin
      src_valid = 1'b1;
      src_byte  = sb(src_sel, i);
      src_last  = (i == src_len[src_sel] - 1);
      do @(posedge clk); while (src_ready !== 1'b1);
      @(negedge clk);
    end
  end
  initial begin
    salt = 8'($urandom(32'h32f6));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    for (int t = 0; t < 6; t++) begin
      new_hdr(t);
      add_timing(1'b1);
      run(5'h01, "timing");
    end
    rx_send(1'b0);
    rx_send(1'b1);
    new_hdr(3);
    add_src(0, 1'b0);
    add_src(1, 1'b0);
    add_timing(1'b1);
    run(5'h02, "send all");
    for (int s = 0; s < 3; s++) begin
      new_hdr(s + 1);
      add_src(s, s != 2);
      if (s == 2) begin
        push(8'h0d, 1'b0);
        push(8'h0a, 1'b1);
      end
      run(5'h04 << s, "forward");
    end
    end_sim();
  end
endmodule
